// ===== rtl/port_b_low_pin_function_select.sv
// Function selector for the eight low port B pins, direction for all sixteen.
// Assumes a same-clock register master and pins from outside the domain;
// arst_n is the power-on reset and nothing else clears the registers.
`timescale 1ns/1ps
`include "pbm_defs.svh"

module port_b_low_pin_function_select (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [`PBM_AW-1:0] reg_addr,
    input wire logic [`PBM_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`PBM_DW-1:0] reg_rdata,
    input wire logic [`PBM_PINS-1:0] pin_in,
    output logic [`PBM_PINS-1:0] pin_out,
    output logic [`PBM_PINS-1:0] pin_oe,
    input wire logic [`PBM_PINS-1:0] gpio_out,
    output logic [`PBM_PINS-1:0] gpio_in,
    input wire logic sync2_tx_data,
    input wire logic sync1_tx_data,
    input wire logic sync1_tx_sync_out,
    input wire logic sync1_tx_sync_oe,
    output logic sync1_tx_sync_in,
    output logic sync1_rx_clock,
    output logic sync1_rx_sync,
    output logic sync1_rx_data,
    output logic sync1_tx_clock,
    input wire logic async2_clock_out,
    input wire logic async2_clock_oe,
    output logic async2_clock_in,
    output logic async2_rx_data,
    input wire logic async2_tx_data,
    input wire logic timer0_a_capcmp_out,
    input wire logic timer0_a_capcmp_oe,
    output logic timer0_a_capcmp_in,
    input wire logic timer0_b_capcmp_out,
    input wire logic timer0_b_capcmp_oe,
    output logic timer0_b_capcmp_in,
    input wire logic timer0_c_capcmp_out,
    input wire logic timer0_c_capcmp_oe,
    output logic timer0_c_capcmp_in,
    input wire logic timer0_d_capcmp_out,
    input wire logic timer0_d_capcmp_oe,
    output logic timer0_d_capcmp_in,
    input wire logic timer2_b_capcmp_out,
    input wire logic timer2_b_capcmp_oe,
    output logic timer2_b_capcmp_in,
    input wire logic timer0_phase_mode,
    input wire logic [`PBM_PSC_W-1:0] timer0_prescale_select,
    input wire logic timer2_phase_mode,
    input wire logic [`PBM_PSC_W-1:0] timer2_prescale_select,
    output logic timer_ext_clock_a,
    output logic timer_ext_clock_b,
    output logic timer_ext_clock_d,
    input wire logic wake_on_lan_out
);

    // ************************************************************
    // State and routing carrier
    // ************************************************************
    pbm_pkg::core_state_s st;
    pbm_pkg::core_state_s next_st;
    pin_route_if rt ();
    logic clk_a_route;
    logic clk_b_route;
    logic clk_d_route;

    pin_route_logic u_route (
        .rt(rt)
    );

    // ************************************************************
    // Timer clock pin takeover
    // ************************************************************
    // clock A on pin 1
    assign clk_a_route = timer0_phase_mode ||
                         (timer0_prescale_select == `PBM_PSC_CLKA);
    assign clk_b_route = timer0_phase_mode ||
                         (timer0_prescale_select == `PBM_PSC_CLKB);
    assign clk_d_route = timer2_phase_mode ||
                         (timer2_prescale_select == `PBM_PSC_CLKD);

    // ************************************************************
    // Alternate drivers per low pin, pin 7 leftmost
    // ************************************************************
    assign rt.func = st.func;
    assign rt.dir = st.dir;
    assign rt.gpio_out = gpio_out;
    assign rt.a1_out = {sync2_tx_data, 1'h0, 1'h0, 1'h0, 1'h0,
                        sync1_tx_sync_out, sync1_tx_data, 1'h0};
    assign rt.a1_oe = {1'h1, 1'h0, 1'h0, 1'h0, 1'h0,
                       sync1_tx_sync_oe, 1'h1, 1'h0};
    assign rt.a2_out = {timer2_b_capcmp_out, async2_clock_out, 1'h0,
                        async2_tx_data, timer0_a_capcmp_out,
                        timer0_b_capcmp_out, timer0_c_capcmp_out,
                        timer0_d_capcmp_out};
    // Clock takeover forces the pin to an input over the compare output
    assign rt.a2_oe = {timer2_b_capcmp_oe && !clk_d_route,
                       async2_clock_oe, 1'h0, 1'h1,
                       timer0_a_capcmp_oe, timer0_b_capcmp_oe,
                       timer0_c_capcmp_oe && !clk_a_route,
                       timer0_d_capcmp_oe && !clk_b_route};
    assign rt.a3_out = {7'h00, wake_on_lan_out};
    assign rt.a3_oe = {7'h00, 1'h1};

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_st = st;
        if (reg_wr) begin
            case (reg_addr)
                `PBM_OFS_FUNC: next_st.func = reg_wdata;
                `PBM_OFS_DIR: next_st.dir = reg_wdata;
                default: ;
            endcase
        end
        // Read data stands one cycle only, zero otherwise
        next_st.rdata = `PBM_RST_VAL;
        if (reg_rd) begin
            case (reg_addr)
                `PBM_OFS_FUNC: next_st.rdata = st.func;
                `PBM_OFS_DIR: next_st.rdata = st.dir;
                default: next_st.rdata = `PBM_RST_VAL;
            endcase
        end
        // Pins are asynchronous to core_clk
        next_st.meta = pin_in;
        next_st.sync = st.meta;
        next_st.gpio_in = st.sync;
        next_st.pad_out = rt.pad_out;
        next_st.pad_oe = rt.pad_oe;
        // Unselected inputs read low, async rx idles high
        next_st.t2b_in = st.sync[`PBM_PIN7] && rt.sel_alt2[`PBM_PIN7];
        next_st.tclk_d = next_st.t2b_in && clk_d_route;
        next_st.s1_rx_clk = st.sync[`PBM_PIN6] &&
                            rt.sel_alt1[`PBM_PIN6];
        next_st.a2_clk_in = st.sync[`PBM_PIN6] &&
                            rt.sel_alt2[`PBM_PIN6];
        next_st.s1_rx_sync = st.sync[`PBM_PIN5] &&
                             rt.sel_alt1[`PBM_PIN5];
        next_st.a2_rx = st.sync[`PBM_PIN5] ||
                        !rt.sel_alt2[`PBM_PIN5];
        next_st.s1_rx_data = st.sync[`PBM_PIN4] &&
                             rt.sel_alt1[`PBM_PIN4];
        next_st.s1_tx_clk = st.sync[`PBM_PIN3] &&
                            rt.sel_alt1[`PBM_PIN3];
        next_st.t0a_in = st.sync[`PBM_PIN3] && rt.sel_alt2[`PBM_PIN3];
        next_st.s1_tx_sync_in = st.sync[`PBM_PIN2] &&
                                rt.sel_alt1[`PBM_PIN2];
        next_st.t0b_in = st.sync[`PBM_PIN2] && rt.sel_alt2[`PBM_PIN2];
        next_st.t0c_in = st.sync[`PBM_PIN1] && rt.sel_alt2[`PBM_PIN1];
        next_st.tclk_a = next_st.t0c_in && clk_a_route;
        next_st.t0d_in = st.sync[`PBM_PIN0] && rt.sel_alt2[`PBM_PIN0];
        next_st.tclk_b = next_st.t0d_in && clk_b_route;
    end

    // ************************************************************
    // State register
    // ************************************************************
    // fields clear to GPIO
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign reg_rdata = st.rdata;
    assign pin_out = st.pad_out;
    assign pin_oe = st.pad_oe;
    assign gpio_in = st.gpio_in;
    assign sync1_tx_sync_in = st.s1_tx_sync_in;
    assign sync1_rx_clock = st.s1_rx_clk;
    assign sync1_rx_sync = st.s1_rx_sync;
    assign sync1_rx_data = st.s1_rx_data;
    assign sync1_tx_clock = st.s1_tx_clk;
    assign async2_clock_in = st.a2_clk_in;
    assign async2_rx_data = st.a2_rx;
    assign timer0_a_capcmp_in = st.t0a_in;
    assign timer0_b_capcmp_in = st.t0b_in;
    assign timer0_c_capcmp_in = st.t0c_in;
    assign timer0_d_capcmp_in = st.t0d_in;
    assign timer2_b_capcmp_in = st.t2b_in;
    assign timer_ext_clock_a = st.tclk_a;
    assign timer_ext_clock_b = st.tclk_b;
    assign timer_ext_clock_d = st.tclk_d;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_FUNC_WRITE:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        reg_wr && reg_addr == `PBM_OFS_FUNC
        ##1 reg_rd && reg_addr == `PBM_OFS_FUNC
        |=> reg_rdata == $past(reg_wdata, 2))
    else $error("function register read back differs");

    AST_RDATA_IDLE:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        !reg_rd |=> reg_rdata == `PBM_RST_VAL)
    else $error("read data not zero outside read answer");

    AST_DIR_GPIO:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[1:0] == 2'h0 |=> pin_oe[0] == $past(st.dir[0]))
    else $error("GPIO pin 0 direction not from direction bit");

    AST_UPPER_GPIO:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        1'h1 |=> pin_oe[15] == $past(st.dir[15]) &&
                 pin_out[15] == $past(gpio_out[15]))
    else $error("pin 15 not steered by direction bit");

    AST_PERIPH_DIR:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[5:4] == 2'h2 |=> pin_oe[2] == $past(timer0_b_capcmp_oe))
    else $error("pin 2 direction not from timer");

    AST_RESERVED_IN:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[15:14] == 2'h3 |=> !pin_oe[7] && !pin_out[7])
    else $error("reserved code drives pin 7");

    AST_RESERVED_PIN4:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[9:8] == 2'h3 |=> !pin_oe[4] && !pin_out[4])
    else $error("reserved code drives pin 4");

    AST_RESERVED_PIN0:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[1:0] == 2'h1 |=> !pin_oe[0] && !pin_out[0])
    else $error("reserved code drives pin 0");

    AST_WOL_OUT:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[1:0] == 2'h3
        |=> pin_oe[0] && pin_out[0] == $past(wake_on_lan_out))
    else $error("wake-on-LAN not on pin 0");

    AST_CLKD_IN:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[15:14] == 2'h2 && clk_d_route |=> !pin_oe[7])
    else $error("pin 7 drives while timer clock D is selected");

    AST_CLKA_IN:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[3:2] == 2'h2 && clk_a_route
        |=> !pin_oe[1] && timer_ext_clock_a == $past(st.sync[1]))
    else $error("pin 1 not routed as timer clock A");

    AST_CLKB_IN:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[1:0] == 2'h2 && clk_b_route
        |=> !pin_oe[0] && timer_ext_clock_b == $past(st.sync[0]))
    else $error("pin 0 not routed as timer clock B");

    AST_SYNC1_TX:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[3:2] == 2'h1
        |=> pin_oe[1] && pin_out[1] == $past(sync1_tx_data))
    else $error("sync1 tx data not on pin 1");

    AST_ASYNC2_RX:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[11:10] == 2'h2 [*3]
        |-> async2_rx_data == $past(pin_in[5], 3))
    else $error("async2 rx data not three cycles behind pin 5");

    AST_SYNC2_TX:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[15:14] == 2'h1
        |=> pin_oe[7] && pin_out[7] == $past(sync2_tx_data))
    else $error("sync2 tx data not on pin 7");

    AST_DIR_WRITE:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        reg_wr && reg_addr == `PBM_OFS_DIR
        ##1 reg_rd && reg_addr == `PBM_OFS_DIR
        |=> reg_rdata == $past(reg_wdata, 2))
    else $error("direction register read back differs");

    AST_HOLE_READ:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        reg_rd && reg_addr != `PBM_OFS_FUNC && reg_addr != `PBM_OFS_DIR
        |=> reg_rdata == `PBM_RST_VAL)
    else $error("unmapped read returns data");

    AST_ASYNC2_TX:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[9:8] == 2'h2
        |=> pin_oe[4] && pin_out[4] == $past(async2_tx_data))
    else $error("async2 tx data not on pin 4");

    AST_SYNC1_RXCLK:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[13:12] == 2'h1
        |=> !pin_oe[6] && sync1_rx_clock == $past(st.sync[6]))
    else $error("pin 6 not routed as sync1 rx clock");

    AST_TIMER0_A:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[7:6] == 2'h2
        |=> pin_oe[3] == $past(timer0_a_capcmp_oe) &&
            pin_out[3] == $past(timer0_a_capcmp_out))
    else $error("pin 3 not steered by timer0 A");

    AST_SYNC1_TXSYNC:
    assert property (@(posedge core_clk) disable iff (!arst_n)
        st.func[5:4] == 2'h1
        |=> pin_oe[2] == $past(sync1_tx_sync_oe) &&
            sync1_tx_sync_in == $past(st.sync[2]))
    else $error("pin 2 not routed as sync1 tx sync");

endmodule

// ===== shared/pbm_defs.svh
// Constants of the lower port B pin function selector.
// Included by the package and the design modules; definitions only.
`ifndef PBM_DEFS_SVH
`define PBM_DEFS_SVH

// ************************************************************
// Register port
// ************************************************************
`define PBM_AW 4
`define PBM_DW 16
`define PBM_OFS_FUNC 4'h0
`define PBM_OFS_DIR 4'h2
`define PBM_RST_VAL 16'h0000

// ************************************************************
// Pin layout
// ************************************************************
`define PBM_PINS 16
`define PBM_LOW_PINS 8
`define PBM_FW 2
`define PBM_ALT1_OK 8'hfe
`define PBM_ALT3_OK 8'h01
`define PBM_PIN0 0
`define PBM_PIN1 1
`define PBM_PIN2 2
`define PBM_PIN3 3
`define PBM_PIN4 4
`define PBM_PIN5 5
`define PBM_PIN6 6
`define PBM_PIN7 7

// ************************************************************
// Timer prescale codes that pick an external clock pin
// ************************************************************
`define PBM_PSC_W 3
`define PBM_PSC_CLKA 3'h4
`define PBM_PSC_CLKB 3'h5
`define PBM_PSC_CLKD 3'h7

`endif

// ===== shared/pbm_pkg.sv
// Types of the lower port B pin function selector.
// Assumes pbm_defs.svh is on the include path.
`include "pbm_defs.svh"

package pbm_pkg;

    typedef enum logic [1:0] {
        FC_GPIO = 2'h0,
        FC_ALT1 = 2'h1,
        FC_ALT2 = 2'h2,
        FC_ALT3 = 2'h3
    } func_code_e;

    typedef enum logic [2:0] {
        PM_GPIO = 3'h0,
        PM_ALT1 = 3'h1,
        PM_ALT2 = 3'h3,
        PM_ALT3 = 3'h2,
        PM_HOLD = 3'h6
    } pin_mode_e;

    typedef struct packed {
        logic [`PBM_DW-1:0] func;
        logic [`PBM_DW-1:0] dir;
        logic [`PBM_DW-1:0] rdata;
        logic [`PBM_PINS-1:0] meta;
        logic [`PBM_PINS-1:0] sync;
        logic [`PBM_PINS-1:0] pad_out;
        logic [`PBM_PINS-1:0] pad_oe;
        logic [`PBM_PINS-1:0] gpio_in;
        logic tclk_a;
        logic tclk_b;
        logic tclk_d;
        logic t0a_in;
        logic t0b_in;
        logic t0c_in;
        logic t0d_in;
        logic t2b_in;
        logic s1_rx_clk;
        logic s1_rx_sync;
        logic s1_rx_data;
        logic s1_tx_clk;
        logic s1_tx_sync_in;
        logic a2_clk_in;
        logic a2_rx;
    } core_state_s;

endpackage

// ===== shared/pin_route_if.sv
// Carrier between the selector core and its pin routing logic.
// Assumes both ends run on one clock; the routing is combinational.
`timescale 1ns/1ps
`include "pbm_defs.svh"

interface pin_route_if;
    logic [`PBM_DW-1:0] func;
    logic [`PBM_PINS-1:0] dir;
    logic [`PBM_PINS-1:0] gpio_out;
    logic [`PBM_LOW_PINS-1:0] a1_out;
    logic [`PBM_LOW_PINS-1:0] a1_oe;
    logic [`PBM_LOW_PINS-1:0] a2_out;
    logic [`PBM_LOW_PINS-1:0] a2_oe;
    logic [`PBM_LOW_PINS-1:0] a3_out;
    logic [`PBM_LOW_PINS-1:0] a3_oe;
    logic [`PBM_LOW_PINS-1:0] sel_alt1;
    logic [`PBM_LOW_PINS-1:0] sel_alt2;
    logic [`PBM_LOW_PINS-1:0] sel_alt3;
    logic [`PBM_PINS-1:0] pad_out;
    logic [`PBM_PINS-1:0] pad_oe;

    modport ctrl (
        output func, dir, gpio_out, a1_out, a1_oe, a2_out, a2_oe,
        output a3_out, a3_oe,
        input sel_alt1, sel_alt2, sel_alt3, pad_out, pad_oe
    );
    modport route (
        input func, dir, gpio_out, a1_out, a1_oe, a2_out, a2_oe,
        input a3_out, a3_oe,
        output sel_alt1, sel_alt2, sel_alt3, pad_out, pad_oe
    );
endinterface

// ===== rtl/pin_route_logic.sv
// Per-pin function decode and output steering for port B.
// Assumes the core registers every result before it reaches a pin.
`timescale 1ns/1ps
`include "pbm_defs.svh"

module pin_route_logic (
    pin_route_if.route rt
);

    // ************************************************************
    // Field decode
    // ************************************************************
    function automatic pbm_pkg::pin_mode_e pin_mode(
        input logic [1:0] code,
        input logic alt1_ok,
        input logic alt3_ok
    );
        pbm_pkg::pin_mode_e m;
        m = pbm_pkg::PM_HOLD;
        case (code)
            pbm_pkg::FC_GPIO: m = pbm_pkg::PM_GPIO;
            pbm_pkg::FC_ALT1: m = alt1_ok ? pbm_pkg::PM_ALT1
                                          : pbm_pkg::PM_HOLD;
            pbm_pkg::FC_ALT2: m = pbm_pkg::PM_ALT2;
            pbm_pkg::FC_ALT3: m = alt3_ok ? pbm_pkg::PM_ALT3
                                          : pbm_pkg::PM_HOLD;
            default: m = pbm_pkg::PM_HOLD;
        endcase
        return m;
    endfunction

    // ************************************************************
    // Steering
    // ************************************************************
    localparam logic [`PBM_LOW_PINS-1:0] ALT1_OK = `PBM_ALT1_OK;
    localparam logic [`PBM_LOW_PINS-1:0] ALT3_OK = `PBM_ALT3_OK;

    genvar n;
    generate
        for (n = 0; n < `PBM_PINS; n++) begin : g_pin
            if (n < `PBM_LOW_PINS) begin : g_low
                pbm_pkg::pin_mode_e m;
                assign m = pin_mode(rt.func[n*`PBM_FW +: `PBM_FW],
                                    ALT1_OK[n], ALT3_OK[n]);
                assign rt.sel_alt1[n] = (m == pbm_pkg::PM_ALT1);
                assign rt.sel_alt2[n] = (m == pbm_pkg::PM_ALT2);
                assign rt.sel_alt3[n] = (m == pbm_pkg::PM_ALT3);
                assign rt.pad_out[n] =
                    (m == pbm_pkg::PM_GPIO) ? rt.gpio_out[n] :
                    (m == pbm_pkg::PM_ALT1) ? rt.a1_out[n] :
                    (m == pbm_pkg::PM_ALT2) ? rt.a2_out[n] :
                    (m == pbm_pkg::PM_ALT3) ? rt.a3_out[n] : 1'h0;
                assign rt.pad_oe[n] =
                    (m == pbm_pkg::PM_GPIO) ? rt.dir[n] :
                    (m == pbm_pkg::PM_ALT1) ? rt.a1_oe[n] :
                    (m == pbm_pkg::PM_ALT2) ? rt.a2_oe[n] :
                    (m == pbm_pkg::PM_ALT3) ? rt.a3_oe[n] : 1'h0;
            end else begin : g_high
                assign rt.pad_out[n] = rt.gpio_out[n];
                assign rt.pad_oe[n] = rt.dir[n];
            end
        end
    endgenerate

endmodule

// ===== verif/far_side.sv
// Far-side model: pin levels and peripheral drives for the selector.
// Assumes stim changes just after a rising edge of the core clock.
`timescale 1ns/1ps

module far_side (
    input wire logic [15:0] stim,
    output logic [15:0] pin_lvl,
    output logic [17:0] drv
);
    // ********
    // Drives
    // ********
    // Peripheral data inverted from the pin so a loopback slip shows; wake-on-LAN data from stim[15]
    assign pin_lvl = stim;
    assign drv = {stim[15], stim[14], ~stim[7], stim[13], ~stim[0],
        stim[12], ~stim[1], stim[11], ~stim[2], stim[10], ~stim[3],
        ~stim[4], stim[9], ~stim[6], stim[8], ~stim[2], ~stim[1], ~stim[7]};
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the lower port B pin function selector.
// Assumes far_side supplies pins and peripherals; one 40 MHz clock.
`timescale 1ns/1ps
`include "pbm_defs.svh"

module testbench;
    typedef struct packed {
        logic [15:0] m;
        logic [15:0] e;
    } note_s;
    logic core_clk = 0;
    logic arst_n = 0;
    logic [3:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic look = 0;
    logic rd_d = 0;
    logic [15:0] stim = 0;
    logic [15:0] gpio_out = 0;
    logic ph0 = 0;
    logic ph2 = 0;
    logic [2:0] p0 = 0;
    logic [2:0] p2 = 0;
    logic [15:0] reg_rdata, pin_lvl, pin_oe, pin_out, f, d, v, gi;
    logic [17:0] drv;
    logic [14:0] mi;
    note_s q[$];
    note_s n;
    int bad_count = 0;
    int tests_run = 0;

    always #12.5 core_clk = ~core_clk;

    far_side fs (.stim, .pin_lvl, .drv);

    port_b_low_pin_function_select dut (
        .core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pin_in(pin_lvl), .pin_out, .pin_oe, .gpio_out,
        .gpio_in(gi), .sync2_tx_data(drv[0]), .sync1_tx_data(drv[1]),
        .sync1_tx_sync_out(drv[2]), .sync1_tx_sync_oe(drv[3]),
        .sync1_tx_sync_in(mi[10]), .sync1_rx_clock(mi[14]),
        .sync1_rx_sync(mi[13]), .sync1_rx_data(mi[12]),
        .sync1_tx_clock(mi[11]), .async2_clock_out(drv[4]),
        .async2_clock_oe(drv[5]), .async2_clock_in(mi[9]),
        .async2_rx_data(mi[8]), .async2_tx_data(drv[6]),
        .timer0_a_capcmp_out(drv[7]), .timer0_a_capcmp_oe(drv[8]),
        .timer0_a_capcmp_in(mi[7]), .timer0_b_capcmp_out(drv[9]),
        .timer0_b_capcmp_oe(drv[10]), .timer0_b_capcmp_in(mi[6]),
        .timer0_c_capcmp_out(drv[11]), .timer0_c_capcmp_oe(drv[12]),
        .timer0_c_capcmp_in(mi[5]), .timer0_d_capcmp_out(drv[13]),
        .timer0_d_capcmp_oe(drv[14]), .timer0_d_capcmp_in(mi[4]),
        .timer2_b_capcmp_out(drv[15]), .timer2_b_capcmp_oe(drv[16]),
        .timer2_b_capcmp_in(mi[3]), .timer0_phase_mode(ph0),
        .timer0_prescale_select(p0), .timer2_phase_mode(ph2),
        .timer2_prescale_select(p2), .timer_ext_clock_a(mi[2]),
        .timer_ext_clock_b(mi[1]), .timer_ext_clock_d(mi[0]),
        .wake_on_lan_out(drv[17])
    );

    // ********
    // Expected pins
    // ********
    function automatic void ref_pins(input logic [15:0] f, d, s,
            output logic [15:0] eo, ev, output logic [14:0] em);
        logic ca, cb, cd;
        ca = ph0 || p0 == `PBM_PSC_CLKA;
        cb = ph0 || p0 == `PBM_PSC_CLKB;
        cd = ph2 || p2 == `PBM_PSC_CLKD;
        eo = d;
        ev = gpio_out;
        em = 15'h0100;
        for (int i = 0; i < 8; i++) begin
            if (f[2*i+:2] != 2'h0) eo[i] = 1'b0;
            case ({i[2:0], f[2*i+:2]})
                5'h02: {eo[0], ev[0], em[4], em[1]} =
                    {s[13] & ~cb, ~s[0], s[0], s[0] & cb};
                5'h03: {eo[0], ev[0]} = {1'b1, s[15]};
                5'h05: {eo[1], ev[1]} = {1'b1, ~s[1]};
                5'h06: {eo[1], ev[1], em[5], em[2]} =
                    {s[12] & ~ca, ~s[1], s[1], s[1] & ca};
                5'h09: {eo[2], ev[2], em[10]} = {s[8], ~s[2], s[2]};
                5'h0a: {eo[2], ev[2], em[6]} = {s[11], ~s[2], s[2]};
                5'h0d: em[11] = s[3];
                5'h0e: {eo[3], ev[3], em[7]} = {s[10], ~s[3], s[3]};
                5'h11: em[12] = s[4];
                5'h12: {eo[4], ev[4]} = {1'b1, ~s[4]};
                5'h15: em[13] = s[5];
                5'h16: em[8] = s[5];
                5'h19: em[14] = s[6];
                5'h1a: {eo[6], ev[6], em[9]} = {s[9], ~s[6], s[6]};
                5'h1d: {eo[7], ev[7]} = {1'b1, ~s[7]};
                5'h1e: {eo[7], ev[7], em[3], em[0]} =
                    {s[14] & ~cd, ~s[7], s[7], s[7] & cd};
                default: ;
            endcase
        end
    endfunction

    // ********
    // Bus and checks
    // ********
    task automatic cyc(input logic w, r, l, input logic [3:0] a,
            input logic [15:0] dv);
        reg_wr <= w;
        reg_rd <= r;
        look <= l;
        reg_addr <= a;
        reg_wdata <= dv;
        @(posedge core_clk);
    endtask

    task automatic rd_exp(input logic [3:0] a, input logic [15:0] e);
        q.push_back('{16'hffff, e});
        cyc(0, 1, 0, a, 16'h0000);
    endtask

    task automatic look_pins(input logic [15:0] f, d);
        logic [15:0] eo, ev;
        logic [14:0] em;
        ref_pins(f, d, stim, eo, ev, em);
        q.push_back('{16'hffff, eo});
        q.push_back('{eo, ev & eo});
        q.push_back('{16'hffff, {1'b0, em}});
        q.push_back('{16'hffff, stim});
        cyc(0, 0, 1, 4'h0, 16'h0000);
    endtask

    task automatic check(input string nm, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    always @(posedge core_clk) begin
        if (rd_d) begin
            n = q.pop_front();
            check("reg_rdata", reg_rdata, n.e);
        end
        if (look) begin
            n = q.pop_front();
            check("pin_oe", pin_oe, n.e);
            n = q.pop_front();
            check("pin_out", pin_out & n.m, n.e);
            n = q.pop_front();
            check("periph_in", {1'b0, mi}, n.e);
            n = q.pop_front();
            check("gpio_in", gi, n.e);
        end
        rd_d <= reg_rd;
    end

    task automatic conclude();
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        conclude();
    end

    // ********
    // Scenarios
    // ********
    initial begin
        void'($urandom(51486));
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        rd_exp(`PBM_OFS_FUNC, 16'h0000);
        rd_exp(`PBM_OFS_DIR, 16'h0000);
        rd_exp(4'h4, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            v = 16'($urandom);
            cyc(1, 0, 0, `PBM_OFS_DIR, v);
            rd_exp(`PBM_OFS_DIR, v);
            cyc(1, 0, 0, 4'h6, ~v);
            rd_exp(`PBM_OFS_DIR, v);
        end
        for (int k = 0; k < 48; k++) begin
            f = k < 4 ? {8{k[1:0]}} : 16'($urandom);
            d = 16'($urandom);
            stim <= 16'($urandom);
            gpio_out <= 16'($urandom);
            ph0 <= ($urandom % 4) == 0;
            ph2 <= ($urandom % 4) == 0;
            p0 <= k[0] ? `PBM_PSC_CLKA + 3'(k[1]) : 3'($urandom);
            p2 <= k[0] ? `PBM_PSC_CLKD : 3'($urandom);
            cyc(1, 0, 0, `PBM_OFS_FUNC, f);
            cyc(1, 0, 0, `PBM_OFS_DIR, d);
            rd_exp(`PBM_OFS_FUNC, f);
            repeat (4) cyc(0, 0, 0, 4'h0, 16'h0000);
            look_pins(f, d);
        end
        cyc(1, 0, 0, `PBM_OFS_DIR, 16'hffff);
        cyc(0, 0, 0, 4'h0, 16'h0000);
        arst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        rd_exp(`PBM_OFS_FUNC, 16'h0000);
        rd_exp(`PBM_OFS_DIR, 16'h0000);
        repeat (4) cyc(0, 0, 0, 4'h0, 16'h0000);
        conclude();
    end
endmodule
